//--- lcd_port_map.svh
`ifndef LCD_PORT_MAP_SVH
`define LCD_PORT_MAP_SVH

// Host clock and link clock timing.
`define CLK_PERIOD_NS 8
`define LINK_HALF_NS 64
`define LINK_HALF_CYCLES (`LINK_HALF_NS / `CLK_PERIOD_NS)
`define STEP_NS 2048
`define STEP_CYCLES (`STEP_NS / `CLK_PERIOD_NS)

// Host register offsets and fields.
`define REG_CTRL 4'h0
`define REG_CMD 4'h4
`define REG_STAT 4'h8
`define CTRL_STYLE 0
`define CTRL_PAR 1
`define CTRL_OSC 2
`define CTRL_MASTER 3
`define CTRL_RUN 4
`define CTRL_FR_EN 5
`define CTRL_FR_LVL 6
`define CTRL_TICK 7
`define CTRL_RESET_VAL 8'h1a
`define CMD_READ 8
`define CMD_DC 9
`define STAT_BUSY 0
`define STAT_DATA_LSB 8
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Device pin sample vector layout.
`define PIN_CS_LOW 0
`define PIN_CS_HIGH 1
`define PIN_DC 2
`define PIN_RD 3
`define PIN_WR 4
`define PIN_STYLE 5
`define PIN_PAR 6
`define PIN_OSC 7
`define PIN_MS 8
`define PIN_TICK 9
`define PIN_FR 10
`define PIN_BUS_LSB 11
`define PIN_SCL 17
`define PIN_SI 18
`define PIN_WIDTH 19

// Device display timing.
`define OSC_LAST 4'hf
`define FR_LAST 4'h7

`endif

//--- lcd_port_pkg.sv
package lcd_port_pkg;

  typedef enum logic [2:0] {
    h_idle = 3'b000,
    h_setup = 3'b001,
    h_strobe = 3'b010,
    h_hold = 3'b011,
    h_serial = 3'b100
  } host_state_type;

endpackage : lcd_port_pkg

//--- lcd_port_if.sv
`timescale 1ns/100ps

interface lcd_port_if;
  logic link_clk;
  logic reset_pin_b;
  logic chip_select_low_b;
  logic chip_select_high;
  logic data_command_select;
  logic read_strobe_b;
  logic store_strobe_b;
  logic bus_style_select;
  logic parallel_serial_select;
  logic osc_source_select;
  logic master_slave_select;
  logic display_tick_input;
  logic [7:0] host_bus_out;
  logic [7:0] host_bus_oe_b;
  logic [7:0] dev_bus_out;
  logic [7:0] dev_bus_oe_b;
  logic host_fr_out;
  logic host_fr_oe_b;
  logic dev_fr_out;
  logic dev_fr_oe_b;
  logic [7:0] host_data_bus;
  logic lcd_ac_polarity_signal;

  // Undriven lines float high, as with a board pull-up.
  assign host_data_bus = (~dev_bus_oe_b & dev_bus_out) | (~host_bus_oe_b & host_bus_out)
    | (dev_bus_oe_b & host_bus_oe_b);
  assign lcd_ac_polarity_signal = (~dev_fr_oe_b & dev_fr_out) | (~host_fr_oe_b & host_fr_out)
    | (dev_fr_oe_b & host_fr_oe_b);

  modport device_end (
    input link_clk, reset_pin_b, chip_select_low_b, chip_select_high, data_command_select,
    input read_strobe_b, store_strobe_b, bus_style_select, parallel_serial_select,
    input osc_source_select, master_slave_select, display_tick_input,
    input host_data_bus, lcd_ac_polarity_signal,
    output dev_bus_out, dev_bus_oe_b, dev_fr_out, dev_fr_oe_b
  );

  modport host_end (
    output link_clk, reset_pin_b, chip_select_low_b, chip_select_high, data_command_select,
    output read_strobe_b, store_strobe_b, bus_style_select, parallel_serial_select,
    output osc_source_select, master_slave_select, display_tick_input,
    output host_bus_out, host_bus_oe_b, host_fr_out, host_fr_oe_b,
    input host_data_bus
  );
endinterface : lcd_port_if

//--- lcd_port_device.sv
// Overview of operation
// - Selected only when low select low, high high.
// - Deselected chip floats all eight data lines.
// - Parallel bytes move over eight-bit two-way bus.
// - Select line high means data, low command.
// - Reset pin low initialises, level not edge.
// - Separate strobes: drive bus while read low.
// - Separate strobes: capture on store strobe rise.
// - Enable style: read pin is high enable.
// - Enable style: direction high reads, low writes.
// - Style strap high enable style, low separate.
// - Serial strap low: bit7 data, bit6 clock.
// - Serial mode floats and ignores bits five-zero.
// - Serial mode: both strobes held at fixed level; the host still moves read when the style strap is rewritten.
// - Serial is write-only; select line still classifies.
// - Oscillator strap high internal, low external tick.
// - Master drives polarity pin, slave reads it.
// - Master strap chooses who sources display timing.
`timescale 1ns/100ps
`include "lcd_port_map.svh"

module lcd_port_device (
  lcd_port_if.device_end link,
  input wire logic rst_b_in,
  input wire logic [7:0] rd_data_in,
  output logic [7:0] rx_byte_out,
  output logic rx_is_data_out,
  output logic rx_valid_out,
  output logic rd_done_out,
  output logic rd_is_data_out,
  output logic display_tick_out,
  output logic ac_polarity_out,
  output logic is_master_out,
  output logic serial_mode_out,
  output logic selected_out
);

  logic init_b;
  logic [`PIN_WIDTH-1:0] pins_raw;
  logic [`PIN_WIDTH-1:0] sync1;
  logic [`PIN_WIDTH-1:0] sync2;
  logic [`PIN_WIDTH-1:0] sync3;
  logic [`PIN_WIDTH-1:0] filt;
  logic [`PIN_WIDTH-1:0] next_filt;
  logic prev_rd;
  logic prev_wr;
  logic prev_scl;
  logic prev_tick;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] rx_byte;
  logic [7:0] next_rx_byte;
  logic rx_is_data;
  logic next_rx_is_data;
  logic rx_valid;
  logic next_rx_valid;
  logic [7:0] rd_latch;
  logic [7:0] next_rd_latch;
  logic drive_bus;
  logic next_drive_bus;
  logic rd_done;
  logic next_rd_done;
  logic rd_is_data;
  logic next_rd_is_data;
  logic [3:0] osc_cnt;
  logic [3:0] next_osc_cnt;
  logic tick;
  logic next_tick;
  logic [3:0] fr_cnt;
  logic [3:0] next_fr_cnt;
  logic fr_level;
  logic next_fr_level;
  logic ac_level;
  logic next_ac_level;
  logic selected;
  logic parallel;
  logic enable_style;
  logic read_active;
  logic write_event;
  logic scl_rise;

  // The reset pin acts on level together with the local reset.
  assign init_b = rst_b_in & link.reset_pin_b;

  assign pins_raw = {
    link.host_data_bus,
    link.lcd_ac_polarity_signal,
    link.display_tick_input,
    link.master_slave_select,
    link.osc_source_select,
    link.parallel_serial_select,
    link.bus_style_select,
    link.store_strobe_b,
    link.read_strobe_b,
    link.data_command_select,
    link.chip_select_high,
    link.chip_select_low_b
  };

  always_comb begin
    // A bit changes only when the second and third stages agree.
    next_filt = (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
    selected = ~filt[`PIN_CS_LOW] & filt[`PIN_CS_HIGH];
    parallel = filt[`PIN_PAR];
    enable_style = filt[`PIN_STYLE];
    scl_rise = 1'b0;
    if (enable_style) begin
      // Read pin is the high-active enable, write pin the direction.
      read_active = selected & parallel & filt[`PIN_RD] & filt[`PIN_WR];
      write_event = selected & parallel & prev_rd & ~filt[`PIN_RD] & ~filt[`PIN_WR];
    end else begin
      read_active = selected & parallel & ~filt[`PIN_RD];
      write_event = selected & parallel & ~prev_wr & filt[`PIN_WR];
    end
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_rx_byte = rx_byte;
    next_rx_is_data = rx_is_data;
    next_rx_valid = 1'b0;
    if (write_event) begin
      next_rx_byte = filt[`PIN_BUS_LSB +: 8];
      next_rx_is_data = filt[`PIN_DC];
      next_rx_valid = 1'b1;
    end
    // Strobes are not looked at in serial mode, so their fixed levels are harmless.
    if (!selected) begin
      next_bit_cnt = 3'h0;
    end else if (!parallel) begin
      scl_rise = ~prev_scl & filt[`PIN_SCL];
      if (scl_rise) begin
        next_shift = {shift[6:0], filt[`PIN_SI]};
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          next_rx_byte = {shift[6:0], filt[`PIN_SI]};
          next_rx_is_data = filt[`PIN_DC];
          next_rx_valid = 1'b1;
        end
      end
    end
    // Reads need parallel mode, so serial mode never drives the bus.
    next_drive_bus = read_active;
    next_rd_latch = rd_latch;
    next_rd_is_data = rd_is_data;
    if (read_active && !drive_bus) begin
      next_rd_latch = rd_data_in;
      next_rd_is_data = filt[`PIN_DC];
    end
    next_rd_done = drive_bus & ~read_active;
    if (filt[`PIN_OSC]) begin
      next_osc_cnt = osc_cnt + 4'h1;
      next_tick = (osc_cnt == `OSC_LAST);
    end else begin
      next_osc_cnt = 4'h0;
      next_tick = filt[`PIN_TICK] & ~prev_tick;
    end
    next_fr_cnt = fr_cnt;
    next_fr_level = fr_level;
    if (tick && filt[`PIN_MS]) begin
      next_fr_cnt = fr_cnt + 4'h1;
      if (fr_cnt == `FR_LAST) begin
        next_fr_cnt = 4'h0;
        next_fr_level = ~fr_level;
      end
    end
    next_ac_level = filt[`PIN_MS] ? fr_level : filt[`PIN_FR];
  end

  always_ff @(posedge link.link_clk or negedge init_b) begin
    if (!init_b) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
      prev_rd <= 1'b0;
      prev_wr <= 1'b0;
      prev_scl <= 1'b0;
      prev_tick <= 1'b0;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      rx_byte <= 8'h00;
      rx_is_data <= 1'b0;
      rx_valid <= 1'b0;
      rd_latch <= 8'h00;
      drive_bus <= 1'b0;
      rd_done <= 1'b0;
      rd_is_data <= 1'b0;
      osc_cnt <= 4'h0;
      tick <= 1'b0;
      fr_cnt <= 4'h0;
      fr_level <= 1'b0;
      ac_level <= 1'b0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      prev_rd <= filt[`PIN_RD];
      prev_wr <= filt[`PIN_WR];
      prev_scl <= filt[`PIN_SCL];
      prev_tick <= filt[`PIN_TICK];
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      rx_byte <= next_rx_byte;
      rx_is_data <= next_rx_is_data;
      rx_valid <= next_rx_valid;
      rd_latch <= next_rd_latch;
      drive_bus <= next_drive_bus;
      rd_done <= next_rd_done;
      rd_is_data <= next_rd_is_data;
      osc_cnt <= next_osc_cnt;
      tick <= next_tick;
      fr_cnt <= next_fr_cnt;
      fr_level <= next_fr_level;
      ac_level <= next_ac_level;
    end
  end

  assign link.dev_bus_out = rd_latch;
  assign link.dev_bus_oe_b = drive_bus ? 8'h00 : 8'hff;
  assign link.dev_fr_out = fr_level;
  assign link.dev_fr_oe_b = ~filt[`PIN_MS];
  assign rx_byte_out = rx_byte;
  assign rx_is_data_out = rx_is_data;
  assign rx_valid_out = rx_valid;
  assign rd_done_out = rd_done;
  assign rd_is_data_out = rd_is_data;
  assign display_tick_out = tick;
  assign ac_polarity_out = ac_level;
  assign is_master_out = filt[`PIN_MS];
  assign serial_mode_out = ~filt[`PIN_PAR];
  assign selected_out = ~filt[`PIN_CS_LOW] & filt[`PIN_CS_HIGH];

endmodule : lcd_port_device

//--- lcd_port_host.sv
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "lcd_port_map.svh"

module lcd_port_host (
  lcd_port_if.host_end link,
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic b_valid, next_b_valid, r_valid, next_r_valid;
  logic [1:0] b_resp, next_b_resp, r_resp, next_r_resp;
  logic [31:0] r_data, next_r_data;
  logic [7:0] ctrl, next_ctrl;
  logic cmd_go;
  lcd_port_pkg::host_state_type state, next_state;
  logic busy, next_busy, is_read, next_is_read, dc, next_dc, active, next_active;
  logic rd_b, next_rd_b, wr_b, next_wr_b;
  logic [7:0] tx, next_tx, bus_out, next_bus_out, bus_oe_b, next_bus_oe_b;
  logic [7:0] rd_byte, next_rd_byte;
  logic [8:0] step, next_step;
  logic [2:0] bit_idx, next_bit_idx;
  logic [2:0] div, next_div;
  logic lclk, next_lclk;
  logic [7:0] s1, s2, s3, filt;
  logic step_end, idle_rd, idle_wr;

  // Register bus: address and data are taken in either order.
  always_comb begin
    awready = ~aw_held & ~b_valid;
    wready = ~w_held & ~b_valid;
    arready = ~r_valid;
    next_aw_held = aw_held | (awvalid & awready);
    next_w_held = w_held | (wvalid & wready);
    next_aw_addr = (awvalid & awready) ? awaddr : aw_addr;
    next_w_data = (wvalid & wready) ? wdata : w_data;
    next_w_strb = (wvalid & wready) ? wstrb : w_strb;
    next_b_valid = b_valid & ~bready;
    next_b_resp = b_resp;
    next_ctrl = ctrl;
    cmd_go = 1'b0;
    if (aw_held && w_held && !b_valid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_b_valid = 1'b1;
      next_b_resp = `RESP_OKAY;
      case (aw_addr)
        `REG_CTRL: if (w_strb[0]) next_ctrl = w_data[7:0];
        `REG_CMD: cmd_go = w_strb[0];
        `REG_STAT: ;
        default: next_b_resp = `RESP_SLVERR;
      endcase
    end
    next_r_valid = r_valid & ~rready;
    next_r_data = r_data;
    next_r_resp = r_resp;
    if (arvalid && arready) begin
      next_r_valid = 1'b1;
      next_r_resp = `RESP_OKAY;
      case (araddr)
        `REG_CTRL: next_r_data = {24'h000000, ctrl};
        `REG_CMD: next_r_data = 32'h00000000;
        `REG_STAT: next_r_data = {16'h0000, rd_byte, 7'h00, busy};
        default: begin
          next_r_data = 32'h00000000;
          next_r_resp = `RESP_SLVERR;
        end
      endcase
    end
  end

  // Link sequencer; setup, strobe, hold and each serial bit last one step so the device's filters settle.
  always_comb begin
    next_div = div + 3'h1;
    next_lclk = (div == 3'(`LINK_HALF_CYCLES - 1)) ? ~lclk : lclk;
    step_end = (step == 9'(`STEP_CYCLES - 1));
    next_step = step_end ? 9'h000 : step + 9'h001;
    // The idle read level tracks a strap write at once, so in serial mode a strobe moves only when the style strap is rewritten.
    idle_rd = ~next_ctrl[`CTRL_STYLE];
    idle_wr = 1'b1;
    next_state = state;
    next_busy = busy;
    next_is_read = is_read;
    next_dc = dc;
    next_tx = tx;
    next_active = active;
    next_rd_b = rd_b;
    next_wr_b = wr_b;
    next_bus_out = bus_out;
    next_bus_oe_b = bus_oe_b;
    next_rd_byte = rd_byte;
    next_bit_idx = bit_idx;
    case (state)
      lcd_port_pkg::h_idle: begin
        next_step = 9'h000;
        next_active = 1'b0;
        next_rd_b = idle_rd;
        next_wr_b = idle_wr;
        next_bus_oe_b = 8'hff;
        // A serial read is refused: the device cannot answer it.
        if (cmd_go && !(w_data[`CMD_READ] && !ctrl[`CTRL_PAR])) begin
          next_state = lcd_port_pkg::h_setup;
          next_busy = 1'b1;
          next_is_read = w_data[`CMD_READ];
          next_dc = w_data[`CMD_DC];
          next_tx = w_data[7:0];
          next_active = 1'b1;
          next_bit_idx = 3'h7;
          if (!ctrl[`CTRL_PAR]) begin
            next_bus_out = {w_data[7], 7'h00};
            next_bus_oe_b = 8'h3f;
          end else begin
            next_bus_out = w_data[7:0];
            next_bus_oe_b = w_data[`CMD_READ] ? 8'hff : 8'h00;
            next_wr_b = ctrl[`CTRL_STYLE] ? w_data[`CMD_READ] : 1'b1;
          end
        end
      end
      lcd_port_pkg::h_setup: if (step_end) begin
        if (!ctrl[`CTRL_PAR]) begin
          next_state = lcd_port_pkg::h_serial;
        end else begin
          next_state = lcd_port_pkg::h_strobe;
          if (ctrl[`CTRL_STYLE]) next_rd_b = 1'b1;
          else if (is_read) next_rd_b = 1'b0;
          else next_wr_b = 1'b0;
        end
      end
      lcd_port_pkg::h_strobe: if (step_end) begin
        next_state = lcd_port_pkg::h_hold;
        if (is_read) next_rd_byte = filt;
        next_rd_b = idle_rd;
        if (!ctrl[`CTRL_STYLE]) next_wr_b = 1'b1;
      end
      lcd_port_pkg::h_serial: begin
        if (step == 9'(`STEP_CYCLES / 2)) next_bus_out[6] = 1'b1;
        if (step_end) begin
          next_bus_out[6] = 1'b0;
          next_bit_idx = bit_idx - 3'h1;
          if (bit_idx == 3'h0) next_state = lcd_port_pkg::h_hold;
          else next_bus_out[7] = tx[bit_idx - 3'h1];
        end
      end
      lcd_port_pkg::h_hold: if (step_end) begin
        next_state = lcd_port_pkg::h_idle;
        next_busy = 1'b0;
        next_active = 1'b0;
        next_bus_oe_b = 8'hff;
      end
      default: next_state = lcd_port_pkg::h_idle;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      b_valid <= 1'b0;
      b_resp <= `RESP_OKAY;
      r_valid <= 1'b0;
      r_resp <= `RESP_OKAY;
      r_data <= 32'h00000000;
      ctrl <= `CTRL_RESET_VAL;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      b_valid <= next_b_valid;
      b_resp <= next_b_resp;
      r_valid <= next_r_valid;
      r_resp <= next_r_resp;
      r_data <= next_r_data;
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= lcd_port_pkg::h_idle;
      busy <= 1'b0;
      is_read <= 1'b0;
      dc <= 1'b0;
      tx <= 8'h00;
      active <= 1'b0;
      rd_b <= 1'b1;
      wr_b <= 1'b1;
      bus_out <= 8'h00;
      bus_oe_b <= 8'hff;
      rd_byte <= 8'h00;
      step <= 9'h000;
      bit_idx <= 3'h0;
      div <= 3'h0;
      lclk <= 1'b0;
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3 <= 8'h00;
      filt <= 8'h00;
    end else begin
      state <= next_state;
      busy <= next_busy;
      is_read <= next_is_read;
      dc <= next_dc;
      tx <= next_tx;
      active <= next_active;
      rd_b <= next_rd_b;
      wr_b <= next_wr_b;
      bus_out <= next_bus_out;
      bus_oe_b <= next_bus_oe_b;
      rd_byte <= next_rd_byte;
      step <= next_step;
      bit_idx <= next_bit_idx;
      div <= next_div;
      lclk <= next_lclk;
      s1 <= link.host_data_bus;
      s2 <= s1;
      s3 <= s2;
      filt <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end
  end

  assign bvalid = b_valid;
  assign bresp = b_resp;
  assign rvalid = r_valid;
  assign rresp = r_resp;
  assign rdata = r_data;
  assign link.link_clk = lclk;
  assign link.reset_pin_b = ctrl[`CTRL_RUN];
  assign link.chip_select_low_b = ~active;
  assign link.chip_select_high = active;
  assign link.data_command_select = dc;
  assign link.read_strobe_b = rd_b;
  assign link.store_strobe_b = wr_b;
  assign link.bus_style_select = ctrl[`CTRL_STYLE];
  assign link.parallel_serial_select = ctrl[`CTRL_PAR];
  assign link.osc_source_select = ctrl[`CTRL_OSC];
  assign link.master_slave_select = ctrl[`CTRL_MASTER];
  assign link.display_tick_input = ctrl[`CTRL_TICK];
  assign link.host_bus_out = bus_out;
  assign link.host_bus_oe_b = bus_oe_b;
  assign link.host_fr_out = ctrl[`CTRL_FR_LVL];
  assign link.host_fr_oe_b = ~ctrl[`CTRL_FR_EN];

endmodule : lcd_port_host

//--- lcd_port_chk.sv
`timescale 1ns/100ps

module lcd_port_chk (
  input wire logic link_clk,
  input wire logic reset_pin_b,
  input wire logic chip_select_low_b,
  input wire logic chip_select_high,
  input wire logic read_strobe_b,
  input wire logic store_strobe_b,
  input wire logic bus_style_select,
  input wire logic parallel_serial_select,
  input wire logic master_slave_select,
  input wire logic [7:0] dev_bus_oe_b,
  input wire logic dev_fr_oe_b
);
  logic sel;
  logic par;
  assign sel = !chip_select_low_b && chip_select_high;
  assign par = parallel_serial_select;
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!reset_pin_b);
  // Eight link cycles outlast the pin filters, so only settled pins are judged.
  sequence s_unsel; (!sel)[*8]; endsequence
  sequence s_rd_sep; (sel && par && !bus_style_select && !read_strobe_b)[*8]; endsequence
  sequence s_idle_sep; (sel && par && !bus_style_select && read_strobe_b)[*8]; endsequence
  sequence s_rd_en; (sel && par && bus_style_select && read_strobe_b && store_strobe_b)[*8];
  endsequence
  sequence s_wr_en; (par && bus_style_select && !store_strobe_b)[*8]; endsequence
  property p_unsel_float; s_unsel |-> dev_bus_oe_b == 8'hff; endproperty
  property p_rd_sep; s_rd_sep |-> dev_bus_oe_b == 8'h00; endproperty
  property p_idle_sep; s_idle_sep |-> dev_bus_oe_b == 8'hff; endproperty
  property p_rd_en; s_rd_en |-> dev_bus_oe_b == 8'h00; endproperty
  property p_wr_en; s_wr_en |-> dev_bus_oe_b == 8'hff; endproperty
  property p_serial_float; (!par)[*8] |-> dev_bus_oe_b == 8'hff; endproperty
  property p_serial_strobes;
    !par && !$past(par) |-> $stable(read_strobe_b) && $stable(store_strobe_b);
  endproperty
  // Reset is a level, so this check must stay live while the pin is low.
  property p_reset_float; disable iff (1'b0) !reset_pin_b |-> dev_bus_oe_b == 8'hff; endproperty
  property p_master_fr; master_slave_select[*8] |-> !dev_fr_oe_b; endproperty
  property p_slave_fr; (!master_slave_select)[*8] |-> dev_fr_oe_b; endproperty
  a_unsel_float: assert property (p_unsel_float)
    else $error("Data bus driven while deselected.");
  a_rd_sep: assert property (p_rd_sep)
    else $error("Data bus not driven during strobed read.");
  a_idle_sep: assert property (p_idle_sep)
    else $error("Data bus driven without read strobe.");
  a_rd_en: assert property (p_rd_en)
    else $error("Data bus not driven during enable read.");
  a_wr_en: assert property (p_wr_en)
    else $error("Data bus driven during enable write.");
  a_serial_float: assert property (p_serial_float)
    else $error("Data bus driven in serial mode.");
  a_serial_strobes: assert property (p_serial_strobes)
    else $error("Strobe moved in serial mode.");
  a_reset_float: assert property (p_reset_float)
    else $error("Data bus driven in reset.");
  a_master_fr: assert property (p_master_fr)
    else $error("Polarity pin not driven as master.");
  a_slave_fr: assert property (p_slave_fr)
    else $error("Polarity pin driven as slave.");
endmodule : lcd_port_chk

//--- lcd_driver_host_port_test.sv
`timescale 1ns/100ps
`include "lcd_port_map.svh"

module lcd_driver_host_port_test;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] rd_data_in = 8'h00;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] rx_byte_out;
  logic rx_is_data_out, rx_valid_out, display_tick_out, ac_polarity_out;
  logic is_master_out, serial_mode_out, selected_out;
  logic rd_done_out, rd_is_data_out;
  int miscompares = 0;
  int cmp_count = 0;
  int ticks = 0;
  logic [8:0] exp_q[$];
  lcd_port_if link_if();
  lcd_port_host lcd_port_host_inst (.link(link_if), .clk_in(clk_in), .rst_b_in(rst_b_in),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  lcd_port_device lcd_port_device_inst (.link(link_if), .rst_b_in(rst_b_in),
    .rd_data_in(rd_data_in), .rx_byte_out(rx_byte_out), .rx_is_data_out(rx_is_data_out),
    .rx_valid_out(rx_valid_out), .rd_done_out(rd_done_out), .rd_is_data_out(rd_is_data_out),
    .display_tick_out(display_tick_out), .ac_polarity_out(ac_polarity_out),
    .is_master_out(is_master_out), .serial_mode_out(serial_mode_out),
    .selected_out(selected_out));
  lcd_port_chk lcd_port_chk_inst (.link_clk(link_if.link_clk), .reset_pin_b(link_if.reset_pin_b),
    .chip_select_low_b(link_if.chip_select_low_b), .chip_select_high(link_if.chip_select_high),
    .read_strobe_b(link_if.read_strobe_b), .store_strobe_b(link_if.store_strobe_b),
    .bus_style_select(link_if.bus_style_select),
    .parallel_serial_select(link_if.parallel_serial_select),
    .master_slave_select(link_if.master_slave_select), .dev_bus_oe_b(link_if.dev_bus_oe_b),
    .dev_fr_oe_b(link_if.dev_fr_oe_b));

  always #4 clk_in = ~clk_in;

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask : axi_rd

  // Busy is polled rather than waited out, since the transfer length depends on the mode.
  task xfer(input logic [9:0] c);
    logic [31:0] s;
    axi_wr(`REG_CMD, {22'h0, c}, `RESP_OKAY);
    do axi_rd(`REG_STAT, s, `RESP_OKAY); while (s[`STAT_BUSY] !== 1'b0);
  endtask : xfer

  task settle(input logic [7:0] c);
    axi_wr(`REG_CTRL, {24'h0, c}, `RESP_OKAY);
    repeat (128) @(posedge clk_in);
  endtask : settle

  task tick_count(input int exp);
    int t0;
    @(posedge link_if.link_clk);
    t0 = ticks;
    repeat (64) @(posedge link_if.link_clk);
    check("display ticks", ticks - t0, exp);
  endtask : tick_count

  always @(posedge link_if.link_clk) begin
    if (display_tick_out === 1'b1) ticks <= ticks + 1;
  end

  always @(posedge link_if.link_clk) begin
    if (rd_done_out === 1'b1) check("read kind", {31'h0, rd_is_data_out}, 32'h1);
    if (rx_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check("stray byte", {23'h0, rx_is_data_out, rx_byte_out},
        '1);
      else check("rx byte", {23'h0, rx_is_data_out, rx_byte_out},
        {23'h0, exp_q.pop_front()});
    end
  end

  // A serial byte takes about 2600 clocks; the whole run needs well under this span.
  initial begin
    #700000;
    miscompares++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] last_rd;
    void'($urandom(32'h1273b59c));
    last_rd = 8'h00;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    axi_rd(`REG_CTRL, r, `RESP_OKAY);
    check("ctrl reset", r, {24'h0, `CTRL_RESET_VAL});
    axi_rd(4'hc, r, `RESP_SLVERR);
    axi_wr(4'hc, 32'h0, `RESP_SLVERR);
    for (int m = 0; m < 3; m++) begin
      c = (m == 2) ? 8'h18 : {7'h0d, m[0]};
      settle(c);
      check("serial mode", {31'h0, serial_mode_out}, {31'h0, m == 2});
      for (int i = 0; i < 4; i++) begin
        b = 8'($urandom);
        exp_q.push_back({i[0], b});
        xfer({i[0], 1'b0, b});
      end
      b = 8'($urandom);
      rd_data_in <= b;
      if (m != 2) last_rd = b;
      xfer(10'h300);
      axi_rd(`REG_STAT, r, `RESP_OKAY);
      check("read byte", {24'h0, r[15:8]}, {24'h0, last_rd});
    end
    settle(8'h0a);
    check("selected in reset", {31'h0, selected_out}, 32'h0);
    xfer(10'h0a5);
    settle(8'h72);
    check("master", {31'h0, is_master_out}, 32'h0);
    check("fr high", {31'h0, ac_polarity_out}, 32'h1);
    settle(8'h32);
    check("fr low", {31'h0, ac_polarity_out}, 32'h0);
    settle(8'h1e);
    tick_count(4);
    settle(8'h1a);
    tick_count(0);
    check("pending bytes", exp_q.size(), 32'h0);
    finish_test();
  end
endmodule : lcd_driver_host_port_test
